/* verilog/swirq_cfg.svh */
`ifndef SWIRQ_CFG_SVH
`define SWIRQ_CFG_SVH

// Register addresses on the device register port
`define SWIRQ_RAW_ADDR       8'hF9
`define SWIRQ_STATUS_ADDR    8'hFB
`define SWIRQ_MASK_ADDR      8'hFD
`define SWIRQ_CLEAR_ADDR     8'hFF

// Reset values
`define SWIRQ_RAW_RST        8'h00
`define SWIRQ_MASK_RST       8'h00
`define SWIRQ_CLEAR_RST      8'h00

// Field positions
`define SWIRQ_BIT_RX_DONE    5
`define SWIRQ_BIT_TX_DONE    4
`define SWIRQ_BIT_RX_TIMEOUT 3
`define SWIRQ_BIT_TUNER_ERR  1
`define SWIRQ_BIT_TUNER_DONE 0

// Implemented bits; 7:6 and 2 are reserved and read zero
`define SWIRQ_VALID_BITS     8'h3B

// Timing
`define SWIRQ_CLK_HZ         50000000
`define SWIRQ_RX_TIMEOUT_MS  100
// Divide first; the product of the two would overflow a 32-bit constant
`define SWIRQ_RX_TIMEOUT_CYC ((`SWIRQ_CLK_HZ / 1000) * `SWIRQ_RX_TIMEOUT_MS)

`endif

/* verilog/swirq_pkg.sv */
package swirq_pkg;

  typedef logic [7:0] reg8_t;

  typedef enum logic [2:0] {
    RX_IDLE    = 3'b001,
    RX_WAIT    = 3'b010,
    RX_EXPIRED = 3'b100
  } rx_state_t;

endpackage : swirq_pkg

/* verilog/swirq_if.sv */
`timescale 1ns/1ns

interface swirq_if;
  swirq_pkg::reg8_t set;
  swirq_pkg::reg8_t clr;
  swirq_pkg::reg8_t raw;

  modport latch (input set, input clr, output raw);
  modport ctrl  (output set, output clr, input raw);
endinterface : swirq_if

/* verilog/event_latch.sv */
`timescale 1ns/1ns
`include "swirq_cfg.svh"

module event_latch
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  swirq_if.latch    ev
);

  swirq_pkg::reg8_t raw_r;
  localparam swirq_pkg::reg8_t VALID = `SWIRQ_VALID_BITS;

  // Sticky raw bits; a set in the clearing cycle wins so no event is lost
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
          raw_r[i] <= 1'b0;
        else if (!VALID[i])
          raw_r[i] <= 1'b0;
        else if (ev.set[i])
          raw_r[i] <= 1'b1;
        else if (ev.clr[i])
          raw_r[i] <= 1'b0;
      end
    end
  endgenerate

  assign ev.raw = raw_r;

endmodule : event_latch

/* verilog/swirq_top.sv */
`timescale 1ns/1ns
`include "swirq_cfg.svh"

module swirq_top
#(
  parameter int unsigned RX_TIMEOUT_CYCLES = `SWIRQ_RX_TIMEOUT_CYC
)
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Device register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Antenna engine
  input  wire logic       antenna_tx_done_in,
  input  wire logic       antenna_rx_start_in,
  input  wire logic       antenna_rx_word_in,
  // Tuner engine
  input  wire logic       tuner_xfer_end_in,
  input  wire logic       tuner_no_resp_in,
  input  wire logic       tuner_nack_in,
  // Combined unmasked hardware status
  input  wire logic       hw_irq_in,
  output logic            host_irq_out
);

  swirq_if ev ();

  event_latch u_latch
  (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ev     (ev.latch)
  );

  localparam swirq_pkg::reg8_t VALID = `SWIRQ_VALID_BITS;
  // Counter is 23 bits wide; the cycle count must not exceed 2**23
  localparam logic [22:0] RX_LIMIT = 23'(RX_TIMEOUT_CYCLES - 1);

  swirq_pkg::reg8_t    mask_r;
  swirq_pkg::reg8_t    clear_r;
  swirq_pkg::reg8_t    status;
  swirq_pkg::reg8_t    set_vec;
  swirq_pkg::reg8_t    rdata_nxt;
  swirq_pkg::rx_state_t rx_state_r;
  swirq_pkg::rx_state_t rx_state_nxt;
  logic [22:0]         rx_cnt_r;
  logic                rx_done_ev;
  logic                rx_timeout_ev;
  logic                tuner_err_ev;
  logic                tuner_done_ev;
  logic                host_irq_r;
  logic                sel_raw;
  logic                sel_status;
  logic                sel_mask;
  logic                sel_clear;
  logic                wr_mask;
  logic                wr_clear;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  // One select per register; unmapped addresses select nothing
  always_comb
  begin
    sel_raw    = 1'b0;
    sel_status = 1'b0;
    sel_mask   = 1'b0;
    sel_clear  = 1'b0;
    if (addr_hit(reg_addr_in, `SWIRQ_RAW_ADDR))
      sel_raw = 1'b1;
    else if (addr_hit(reg_addr_in, `SWIRQ_STATUS_ADDR))
      sel_status = 1'b1;
    else if (addr_hit(reg_addr_in, `SWIRQ_MASK_ADDR))
      sel_mask = 1'b1;
    else if (addr_hit(reg_addr_in, `SWIRQ_CLEAR_ADDR))
      sel_clear = 1'b1;
  end

  // Raw and status are read-only, so only two registers take writes
  assign wr_mask  = reg_wr_in && sel_mask;
  assign wr_clear = reg_wr_in && sel_clear;

  // Mask-enable register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      mask_r <= `SWIRQ_MASK_RST;
    else if (wr_mask)
      mask_r <= reg_wdata_in & VALID;
  end

  // Clear bits are one-cycle strobes that drop back to zero on their own
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      clear_r <= `SWIRQ_CLEAR_RST;
    else if (wr_clear)
      clear_r <= reg_wdata_in & VALID;
    else
      clear_r <= `SWIRQ_CLEAR_RST;
  end

  // Antenna receive wait timer
  always_comb
  begin
    rx_state_nxt = rx_state_r;
    case (rx_state_r)
      swirq_pkg::RX_IDLE:
      begin
        if (antenna_rx_start_in)
          rx_state_nxt = swirq_pkg::RX_WAIT;
      end
      swirq_pkg::RX_WAIT:
      begin
        if (antenna_rx_word_in)
          rx_state_nxt = swirq_pkg::RX_IDLE;
        else if (rx_cnt_r == RX_LIMIT)
          rx_state_nxt = swirq_pkg::RX_EXPIRED;
      end
      swirq_pkg::RX_EXPIRED:
      begin
        rx_state_nxt = swirq_pkg::RX_IDLE;
      end
      default:
      begin
        rx_state_nxt = swirq_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rx_state_r <= swirq_pkg::RX_IDLE;
    else
      rx_state_r <= rx_state_nxt;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rx_cnt_r <= 23'h00_0000;
    else if (rx_state_r == swirq_pkg::RX_WAIT)
      rx_cnt_r <= rx_cnt_r + 23'h00_0001;
    else
      rx_cnt_r <= 23'h00_0000;
  end

  // Late word after expiry is ignored; the receive already counts as failed
  assign rx_done_ev    = (rx_state_r == swirq_pkg::RX_WAIT) && antenna_rx_word_in;
  assign rx_timeout_ev = (rx_state_r == swirq_pkg::RX_EXPIRED);
  assign tuner_err_ev  = tuner_xfer_end_in && (tuner_no_resp_in || tuner_nack_in);
  assign tuner_done_ev = tuner_xfer_end_in && !tuner_no_resp_in && !tuner_nack_in;

  always_comb
  begin
    set_vec = 8'h00;
    set_vec[`SWIRQ_BIT_RX_DONE]    = rx_done_ev;
    set_vec[`SWIRQ_BIT_TX_DONE]    = antenna_tx_done_in;
    set_vec[`SWIRQ_BIT_RX_TIMEOUT] = rx_timeout_ev;
    set_vec[`SWIRQ_BIT_TUNER_ERR]  = tuner_err_ev;
    set_vec[`SWIRQ_BIT_TUNER_DONE] = tuner_done_ev;
  end

  assign ev.set = set_vec;
  assign ev.clr = clear_r;

  // Status is never stored, so it falls with its raw bit
  assign status = ev.raw & mask_r;

  // Request follows status one cycle later
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      host_irq_r <= 1'b0;
    else
      host_irq_r <= (|status) || hw_irq_in;
  end

  assign host_irq_out = host_irq_r;

  always_comb
  begin
    if (sel_raw)
      rdata_nxt = ev.raw;
    else if (sel_status)
      rdata_nxt = status;
    else if (sel_mask)
      rdata_nxt = mask_r;
    else
      rdata_nxt = 8'h00;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
      reg_rdata_out <= rdata_nxt;
  end

endmodule : swirq_top

/* tb/swirq_props.sv */
`timescale 1ns/1ns
module swirq_props
(
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       hw_irq_in,
  input wire logic       host_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] mask_r;
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      mask_r <= 8'h00;
    else if (reg_wr_in && reg_addr_in == 8'hFD)
      mask_r <= reg_wdata_in & 8'h3B;
  end
  a_irq_reset_low: assert property (disable iff (1'b0) rst_in |=> !host_irq_out)
    else $error("request high after reset");
  a_reserved_zero: assert property ((reg_rdata_out & 8'hC4) == 8'h00)
    else $error("reserved bit read high");
  a_hw_irq_pass: assert property (hw_irq_in |=> host_irq_out)
    else $error("hardware request not passed");
  a_clear_reads_zero: assert property (reg_rd_in && reg_addr_in == 8'hFF |=> reg_rdata_out == 8'h00)
    else $error("clear register read nonzero");
  a_mask_read_back: assert property (reg_rd_in && !reg_wr_in && reg_addr_in == 8'hFD |=> reg_rdata_out == mask_r)
    else $error("mask read mismatch");
  a_status_under_mask: assert property (reg_rd_in && !reg_wr_in && reg_addr_in == 8'hFB |=>
    (reg_rdata_out & ~mask_r) == 8'h00)
    else $error("status bit set while masked");
  a_masked_quiet: assert property (mask_r == 8'h00 && !hw_irq_in |=> !host_irq_out)
    else $error("request with all masked");
  a_drop_has_cause: assert property ($fell(host_irq_out) |-> $past(reg_wr_in, 2) || $past(reg_wr_in, 3) ||
    ($past(hw_irq_in, 2) && !$past(hw_irq_in)) || $past(rst_in))
    else $error("request dropped without cause");
  c_irq_rise: cover property ($rose(host_irq_out));
  c_mask_read: cover property (reg_rd_in && reg_addr_in == 8'hFD);
  c_clear_write: cover property (reg_wr_in && reg_addr_in == 8'hFF);
endmodule : swirq_props
bind swirq_top swirq_props swirq_props_inst
(
  .clk_in        (clk_in),
  .rst_in        (rst_in),
  .reg_addr_in   (reg_addr_in),
  .reg_wr_in     (reg_wr_in),
  .reg_wdata_in  (reg_wdata_in),
  .reg_rd_in     (reg_rd_in),
  .reg_rdata_out (reg_rdata_out),
  .hw_irq_in     (hw_irq_in),
  .host_irq_out  (host_irq_out)
);

/* tb/host_model.sv */
`timescale 1ns/1ns
module host_model
(
  input  wire logic clk_in,
  input  wire logic irq_in,
  output int        irq_seen_out
);
  // Host only polls the level; it counts cycles seen high
  always_ff @(posedge clk_in)
    irq_seen_out <= irq_seen_out + int'(irq_in);
endmodule : host_model

/* tb/software_interrupt_status_mask_bench.sv */
`timescale 1ns/1ns
module software_interrupt_status_mask_bench;
  logic       clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, hw_irq_in = 0, host_irq_out;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic       tx_in = 0, start_in = 0, word_in = 0, end_in = 0, noresp_in = 0, nack_in = 0;
  int         n_errors = 0, tests_run = 0, seed = 77, raw = 0, mask = 0, seen;
  int         bits [6] = '{16, 1, 2, 2, 8, 32};
  always #10 clk_in = ~clk_in;
  swirq_top #(.RX_TIMEOUT_CYCLES(20)) swirq_top_inst (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .antenna_tx_done_in(tx_in), .antenna_rx_start_in(start_in), .antenna_rx_word_in(word_in),
    .tuner_xfer_end_in(end_in), .tuner_no_resp_in(noresp_in), .tuner_nack_in(nack_in), .hw_irq_in(hw_irq_in),
    .host_irq_out(host_irq_out));
  host_model host_model_inst (.clk_in(clk_in), .irq_in(host_irq_out), .irq_seen_out(seen));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1;
    step(1);
    reg_wr_in = 0;
    // Idle edge keeps back-to-back strobes apart
    step(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input int e);
    reg_addr_in = a;
    reg_rd_in = 1;
    step(1);
    reg_rd_in = 0;
    chk("rdata", e[7:0], reg_rdata_out);
    step(1);
  endtask : rd
  task automatic ev(input int k);
    // Receive cases open a wait first; case 4 runs out, then sends a late word
    if (k > 3)
    begin
      start_in = 1;
      step(1);
      start_in = 0;
      step(k == 4 ? 20 : 3);
      if (k == 4)
        rd(8'hF9, 0);
    end
    case (k)
      0: tx_in = 1;
      1: end_in = 1;
      2: {end_in, nack_in} = 2'b11;
      3: {end_in, noresp_in} = 2'b11;
      default: word_in = 1;
    endcase
    step(1);
    {tx_in, word_in, end_in, noresp_in, nack_in} = 5'h00;
  endtask : ev
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial
  begin
    step(9000);
    n_errors++;
    end_sim;
  end
  initial
  begin
    step(16);
    rst_in = 0;
    rd(8'hFD, 0);
    rd(8'hFB, 0);
    for (int k = 0; k < 6; k++)
    begin
      wr(8'hFD, 8'($random(seed)));
      mask = reg_wdata_in & 8'h3B;
      rd(8'hFD, mask);
      ev(k);
      step(2);
      raw |= bits[k];
      rd(8'hF9, raw);
      rd(8'hFB, raw & mask);
      chk_bit("irq", (raw & mask) != 0, host_irq_out);
      wr(8'hFF, 8'(raw));
      raw = 0;
      step(3);
      rd(8'hFF, 0);
      rd(8'hF9, 0);
      rd(8'hFB, 0);
      chk_bit("irq", 1'b0, host_irq_out);
    end
    hw_irq_in = 1;
    step(2);
    chk_bit("irq", 1'b1, host_irq_out);
    chk_bit("host", 1'b1, seen != 0);
    hw_irq_in = 0;
    step(2);
    chk_bit("irq", 1'b0, host_irq_out);
    // Reset in mid-run must drop mask, status and request
    wr(8'hFD, 8'h3B);
    ev(0);
    step(2);
    chk_bit("irq", 1'b1, host_irq_out);
    rst_in = 1;
    step(2);
    rst_in = 0;
    rd(8'hFD, 0);
    rd(8'hFB, 0);
    chk_bit("irq", 1'b0, host_irq_out);
    end_sim;
  end
endmodule : software_interrupt_status_mask_bench
